// >>> core/brc_pkg.sv
// Constants, types and shared figures for the bidirectional reset control block
// Notes on behaviour
// [R1] Enable write ignored after end of init
// [R2] Enable bit cleared by every reset
// [R3] Bidirectional mode reports long hardware reset
// [R4] Boot port sampled on pin-started and bidirectional resets only
// [R5] Low select bit enables bootstrap loader
// [R6] External reset sources use open drain
// [R7] Short external reset stretched to sequence in bidirectional mode
// [R8] Pin pulled low during whole sequence in bidirectional mode
// [R9] Low reset pin starts a reset
// [R10] Pin undriven when bidirectional mode off
package brc_pkg;
    // ****************************************
    // Timing and widths
    // ****************************************
    localparam int          SEQ_CYCLES_DEF = 1024; // Internal reset sequence, clk cycles
    localparam int          BOOT_W         = 16;   // Boot configuration port width
    localparam int          BOOT_SEL_BIT   = 4;    // Bootstrap loader select bit position
    localparam logic        PIN_LOW        = 1'b0; // Level the pin driver pulls to
    localparam logic        EN_RST         = 1'b0; // Enable value after any reset
    localparam logic [15:0] BOOT_RST       = 16'hFFFF;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0]
    {
        CAUSE_HW_LONG  = 2'h0,
        CAUSE_HW_SHORT = 2'h1,
        CAUSE_SW       = 2'h2,
        CAUSE_WDT      = 2'h3
    } brc_cause_t;

    typedef enum logic [1:0]
    {
        ST_RUN  = 2'h0,
        ST_SEQ  = 2'h1,
        ST_HOLD = 2'h2
    } brc_state_t;
endpackage

// >>> core/brc_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module brc_sync
#(
    parameter int          WIDTH = 1,
    parameter logic [15:0] RST   = 16'h0000
)
(
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] level_d;

    // A bit changes only once stages two and three agree
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            level_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : level[i];
        end
    end

    // Shift chain and filtered level
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s1_q  <= RST[WIDTH-1:0];
            s2_q  <= RST[WIDTH-1:0];
            s3_q  <= RST[WIDTH-1:0];
            level <= RST[WIDTH-1:0];
        end
        else
        begin
            s1_q  <= pin;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            level <= level_d;
        end
    end
endmodule

// >>> core/brc_reset_ctrl.sv
// Reset control with bidirectional reset pin, cause flags and boot sampling
`timescale 1ns/10ps
module brc_reset_ctrl
#(
    parameter int SEQ_CYCLES = brc_pkg::SEQ_CYCLES_DEF
)
(
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    input  wire logic                       reset_in_pin_i,
    output logic                            reset_in_pin_o,
    output logic                            reset_in_pin_oe,
    input  wire logic [brc_pkg::BOOT_W-1:0] boot_config_port,
    input  wire logic                       end_of_init_instruction,
    input  wire logic                       sw_reset_req,
    input  wire logic                       watchdog_timer_reset,
    input  wire logic                       cfg_wr,
    input  wire logic                       cfg_bidir_reset_enable,
    output logic                            bidir_reset_enable,
    output logic                            internal_reset,
    output brc_pkg::brc_cause_t             reset_cause,
    output logic [brc_pkg::BOOT_W-1:0]      boot_config_q,
    output logic                            boot_loader_select,
    output logic                            init_done
);
    localparam int CNT_W = $clog2(SEQ_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SEQ_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

    brc_pkg::brc_state_t         st_q, st_d;
    brc_pkg::brc_cause_t         cause_d;
    logic [CNT_W-1:0]            cnt_q, cnt_d;
    logic                        en_d;
    logic                        seq_bidir_q, seq_bidir_d;
    logic                        hw_q, hw_d;
    logic                        init_d;
    logic [brc_pkg::BOOT_W-1:0]  boot_d;
    logic                        bl_d;
    logic                        pin_level;
    logic [brc_pkg::BOOT_W-1:0]  boot_level;
    logic                        pin_low;
    logic                        cnt_done;
    logic                        finish;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    brc_sync #(.WIDTH(1), .RST(16'h0001)) u_pin_sync
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (reset_in_pin_i),
        .level   (pin_level)
    );

    brc_sync #(.WIDTH(brc_pkg::BOOT_W), .RST(brc_pkg::BOOT_RST)) u_boot_sync
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (boot_config_port),
        .level   (boot_level)
    );

    assign pin_low  = (pin_level == brc_pkg::PIN_LOW);
    assign cnt_done = (cnt_q == CNT_LAST);

    // ****************************************
    // Reset sequencer
    // ****************************************
    // Next state, counter, enable bit, cause flags and boot sample
    always_comb
    begin
        st_d        = st_q;
        cnt_d       = cnt_q;
        en_d        = bidir_reset_enable;
        seq_bidir_d = seq_bidir_q;
        hw_d        = hw_q;
        init_d      = init_done;
        cause_d     = reset_cause;
        boot_d      = boot_config_q;
        bl_d        = boot_loader_select;
        finish      = 1'b0;
        case (st_q)
            brc_pkg::ST_RUN:
            begin
                // [R9] pin low resets
                if (pin_low || watchdog_timer_reset || sw_reset_req)
                begin
                    st_d        = brc_pkg::ST_SEQ;
                    cnt_d       = CNT_ZERO;
                    seq_bidir_d = bidir_reset_enable;
                    hw_d        = pin_low;
                    init_d      = 1'b0;
                    // [R2] clear enable bit
                    en_d        = brc_pkg::EN_RST;
                    // [R3] force long cause
                    if (bidir_reset_enable || pin_low)
                        cause_d = brc_pkg::CAUSE_HW_LONG;
                    else if (watchdog_timer_reset)
                        cause_d = brc_pkg::CAUSE_WDT;
                    else
                        cause_d = brc_pkg::CAUSE_SW;
                end
                else
                begin
                    // [R1] write locked after init
                    if (cfg_wr && !init_done)
                        en_d = cfg_bidir_reset_enable;
                    if (end_of_init_instruction)
                        init_d = 1'b1;
                end
            end
            brc_pkg::ST_SEQ:
            begin
                if (!cnt_done)
                    cnt_d = cnt_q + CNT_ONE;
                // [R7] stretch to full sequence
                if (seq_bidir_q)
                begin
                    if (cnt_done)
                        st_d = brc_pkg::ST_HOLD;
                end
                else if (hw_q)
                begin
                    // Plain input mode: reset follows the pin
                    if (!pin_low)
                    begin
                        cause_d = cnt_done ? brc_pkg::CAUSE_HW_LONG
                                           : brc_pkg::CAUSE_HW_SHORT;
                        finish  = 1'b1;
                    end
                end
                else if (cnt_done)
                    finish = 1'b1;
            end
            brc_pkg::ST_HOLD:
            begin
                // Wait for the line to rise after release
                if (!pin_low)
                    finish = 1'b1;
            end
            default:
                st_d = brc_pkg::ST_RUN;
        endcase
        if (finish)
        begin
            st_d = brc_pkg::ST_RUN;
            // [R4] sample boot port
            if (hw_q || seq_bidir_q)
            begin
                boot_d = boot_level;
                // [R5] loader select low
                bl_d   = (boot_level[brc_pkg::BOOT_SEL_BIT] == brc_pkg::PIN_LOW);
            end
        end
    end

    // Sequencer registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_q               <= brc_pkg::ST_RUN;
            cnt_q              <= CNT_ZERO;
            bidir_reset_enable <= brc_pkg::EN_RST;
            seq_bidir_q        <= 1'b0;
            hw_q               <= 1'b0;
            init_done          <= 1'b0;
            reset_cause        <= brc_pkg::CAUSE_HW_LONG;
            boot_config_q      <= brc_pkg::BOOT_RST;
            boot_loader_select <= 1'b0;
        end
        else
        begin
            st_q               <= st_d;
            cnt_q              <= cnt_d;
            bidir_reset_enable <= en_d;
            seq_bidir_q        <= seq_bidir_d;
            hw_q               <= hw_d;
            init_done          <= init_d;
            reset_cause        <= cause_d;
            boot_config_q      <= boot_d;
            boot_loader_select <= bl_d;
        end
    end

    // ****************************************
    // Pin driver and status
    // ****************************************
    // [R8] pull pin during sequence
    assign reset_in_pin_o  = brc_pkg::PIN_LOW;
    // [R10] undriven when disabled
    assign reset_in_pin_oe = seq_bidir_q && (st_q == brc_pkg::ST_SEQ);
    assign internal_reset  = (st_q != brc_pkg::ST_RUN);

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence seq_start_s;
        (st_q == brc_pkg::ST_RUN) ##1 (st_q == brc_pkg::ST_SEQ);
    endsequence

    sequence bidir_start_s;
        seq_start_s ##0 seq_bidir_q;
    endsequence

    // [R1] locked enable write
    enable_lock_a: assert property (init_done && st_q == brc_pkg::ST_RUN && !sw_reset_req
        && !watchdog_timer_reset && !pin_low |=> $stable(bidir_reset_enable)) // [R1]
        else $error("enable bit changed after end of init");

    // [R2] enable cleared on reset
    enable_clear_a: assert property (seq_start_s |-> !bidir_reset_enable) // [R2]
        else $error("enable bit not cleared by reset");

    // [R3] long cause in bidir
    cause_long_a: assert property (bidir_start_s |-> reset_cause == brc_pkg::CAUSE_HW_LONG) // [R3]
        else $error("bidirectional reset not reported as long hardware reset");

    // [R4] boot sampled on finish
    boot_sample_a: assert property ((st_q != brc_pkg::ST_RUN) && finish && seq_bidir_q
        |=> boot_config_q == $past(boot_level)) // [R4]
        else $error("boot port not sampled in bidirectional reset");

    // [R5] loader select follows bit
    loader_sel_a: assert property ($changed(boot_config_q)
        |-> boot_loader_select == !boot_config_q[brc_pkg::BOOT_SEL_BIT]) // [R5]
        else $error("loader select disagrees with sampled bit");

    // [R7] reset held for 8 cycles in bidir
    stretch_full_a: assert property (bidir_start_s |-> internal_reset [*8]) // [R7]
        else $error("bidirectional reset sequence cut short");

    // [R8] pin driven for first 8 cycles of sequence
    pin_drive_a: assert property (bidir_start_s |-> reset_in_pin_oe [*8]) // [R8]
        else $error("pin released during sequence");

    // [R9] pin low enters reset
    pin_reset_a: assert property ($fell(pin_level) && !internal_reset
        |=> internal_reset) // [R9]
        else $error("low reset pin did not start reset");

    // [R10] never driven when off
    pin_idle_a: assert property (!seq_bidir_q |-> !reset_in_pin_oe) // [R10]
        else $error("pin driven with bidirectional mode off");
endmodule

// >>> verification/brc_ext_source.sv
// Open-drain external reset source sharing the reset pin with the device
`timescale 1ns/10ps
module brc_ext_source
(
    input  wire logic pull_low,
    input  wire logic dev_o,
    input  wire logic dev_oe,
    output logic      pin
);
    // open drain only
    // Wire-AND of both parties; a released line floats high on the pull-up
    assign pin = (pull_low || (dev_oe && !dev_o)) ? 1'h0 : 1'h1;
endmodule

// >>> verification/bidirectional_reset_control_tb_top.sv
// Self-checking bench for the bidirectional reset control block
`timescale 1ns/10ps
module bidirectional_reset_control_tb_top;
    localparam int       SEQ = 8;
    logic                clk = 1'h0;
    logic                sys_rst = 1'h1;
    logic                ext_low = 1'h0;
    logic                pin;
    logic                pin_o;
    logic                pin_oe;
    logic                en;
    logic                irst;
    logic                sel;
    logic                idone;
    logic [15:0]         boot = 16'hFFFF;
    logic [15:0]         boot_q;
    logic                eoi = 1'h0;
    logic                swr = 1'h0;
    logic                wdr = 1'h0;
    logic                wr = 1'h0;
    logic                wdat = 1'h0;
    brc_pkg::brc_cause_t cause;
    int                  error_cnt = 0;
    int                  comparisons = 0;
    int                  cyc = 0;

    always #10 clk = ~clk;

    brc_reset_ctrl #(.SEQ_CYCLES(SEQ)) uut
    (
        .clk(clk), .sys_rst(sys_rst), .reset_in_pin_i(pin), .reset_in_pin_o(pin_o),
        .reset_in_pin_oe(pin_oe), .boot_config_port(boot), .end_of_init_instruction(eoi),
        .sw_reset_req(swr), .watchdog_timer_reset(wdr), .cfg_wr(wr),
        .cfg_bidir_reset_enable(wdat), .bidir_reset_enable(en), .internal_reset(irst),
        .reset_cause(cause), .boot_config_q(boot_q), .boot_loader_select(sel),
        .init_done(idone)
    );

    brc_ext_source ext (.pull_low(ext_low), .dev_o(pin_o), .dev_oe(pin_oe), .pin(pin));

    // Compares one value and counts it
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Writes the enable bit through the strobe
    task automatic wr_en(input logic v);
        @(posedge clk);
        wr <= 1'h1;
        wdat <= v;
        @(posedge clk);
        wr <= 1'h0;
        @(negedge clk);
    endtask

    // One-cycle pulse: 0 end of init, 1 software reset, 2 watchdog
    task automatic pulse(input int k);
        @(posedge clk);
        eoi <= (k == 0);
        swr <= (k == 1);
        wdr <= (k == 2);
        @(posedge clk);
        eoi <= 1'h0;
        swr <= 1'h0;
        wdr <= 1'h0;
    endtask

    // External source holds the pin low for n clock cycles
    task automatic hold_low(input int n);
        @(posedge clk);
        ext_low <= 1'h1;
        repeat (n) @(posedge clk);
        ext_low <= 1'h0;
    endtask

    // Follows one reset: pull-down cycles, cause, length
    task automatic measure(input int oe_n, input logic [1:0] cs, input int min_len);
        int n;
        int n_oe;
        n = 0;
        n_oe = 0;
        while (irst !== 1'h1 && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        chk("enable cleared", 16'h0, {15'h0, en});
        n = 0;
        while (irst === 1'h1 && n < 200)
        begin
            if (pin_oe === 1'h1)
            begin
                n_oe++;
                chk("pin level", {15'h0, brc_pkg::PIN_LOW}, {15'h0, pin_o});
            end
            n++;
            @(negedge clk);
        end
        chk("pull cycles", oe_n[15:0], n_oe[15:0]);
        chk("reset long enough", 16'h1, {15'h0, (n >= min_len)});
        chk("cause", {14'h0, cs}, {14'h0, cause});
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Cuts a hang short
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'h0;
        @(negedge clk);
        chk("enable after reset", {15'h0, brc_pkg::EN_RST}, {15'h0, en});
        chk("pin released", 16'h0, {15'h0, pin_oe});
        chk("boot reset", brc_pkg::BOOT_RST, boot_q);
        $display("test power_on done");
        wr_en(1'h1);
        chk("enable set", 16'h1, {15'h0, en});
        pulse(0);
        wr_en(1'h0);
        chk("enable locked", 16'h1, {15'h0, en});
        chk("init done", 16'h1, {15'h0, idone});
        $display("test lock done");
        @(posedge clk);
        boot <= 16'hFFEF;
        pulse(1);
        measure(SEQ, 2'h0, SEQ);
        chk("boot sw", 16'hFFEF, boot_q);
        chk("loader select", 16'h1, {15'h0, sel});
        chk("enable after seq", 16'h0, {15'h0, en});
        chk("init cleared", 16'h0, {15'h0, idone});
        $display("test bidir_sw done");
        @(posedge clk);
        boot <= 16'h1234;
        pulse(1);
        measure(0, 2'h2, SEQ);
        chk("boot kept", 16'hFFEF, boot_q);
        $display("test plain_sw done");
        wr_en(1'h1);
        pulse(2);
        measure(SEQ, 2'h0, SEQ);
        chk("boot wdt", 16'h1234, boot_q);
        chk("loader off", 16'h0, {15'h0, sel});
        $display("test bidir_wdt done");
        wr_en(1'h1);
        fork
            hold_low(5);
            measure(SEQ, 2'h0, SEQ);
        join
        $display("test bidir_short_hw done");
        fork
            hold_low(5);
            measure(0, 2'h1, 1);
        join
        $display("test plain_short_hw done");
        @(posedge clk);
        boot <= 16'hABCD;
        pulse(2);
        measure(0, 2'h3, SEQ);
        chk("boot kept wdt", 16'h1234, boot_q);
        $display("test plain_wdt done");
        fork
            hold_low(20);
            measure(0, 2'h0, SEQ);
        join
        chk("boot hw", 16'hABCD, boot_q);
        $display("test plain_long_hw done");
        tally_and_finish();
    end
endmodule
